// ### dcc_top.sv
`timescale 1ns/1ps
// What this block does
// - Two comparators, each with own control
// - Input sources selectable by register fields
// - Output enable routes raw result, xor invert bit, to pin while bit 15 set
// - Clear, set, invert aliases at +4,+8,+C
// - Status bit 17 mirrors second event
// - Status bit 16 mirrors first event
// - Status bit 1 mirrors second result
// - Status bit 0 mirrors first result
// - Idle halt bit stops comparators in idle
// - Status bit 8 selects reference source
// - Unimplemented bits zero, reset all zero
// - Event flag sticky, blocks triggers until cleared
// - Two-bit field selects event condition
// - Invert bit inverts reported result
// - Bit 15 enables comparator
module dcc_top
   import dcc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic sysIdle,
   input wire logic rawResultOne,
   input wire logic rawResultTwo,
   output logic resultPinOne,
   output logic resultPinTwo,
   output logic enableOne,
   output logic enableTwo,
   output logic positiveSelOne,
   output logic positiveSelTwo,
   output logic [1:0] negativeSelOne,
   output logic [1:0] negativeSelTwo,
   output logic referenceSourceSelect
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [31:0] ctl1;
      logic [31:0] ctl2;
      logic idleHalt;
      logic refSel;
      logic idleS1;
      logic idleS2;
   } dcc_top_st_t;
   dcc_top_st_t st_q, st_d;

   dcc_chan_if ifOne();
   dcc_chan_if ifTwo();
   logic runOk;
   logic clr1, clr2;
   logic [31:0] stat, ctl1Rd, ctl2Rd, wdat, bmask, cur, nxt;
   logic [7:0] ofs;
   logic hit, wrStb;
   dcc_op_t op;

   assign runOk = !(st_q.idleHalt && st_q.idleS2);

   dcc_channel u_one (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .rawResult(rawResultOne),
      .runOk(runOk),
      .ch(ifOne.chan)
   );
   dcc_channel u_two (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .rawResult(rawResultTwo),
      .runOk(runOk),
      .ch(ifTwo.chan)
   );

   assign ifOne.enable = st_q.ctl1[CTL_ON];
   assign ifOne.invert = st_q.ctl1[CTL_INV];
   assign ifOne.event_polarity_field = st_q.ctl1[CTL_EVP +: 2];
   assign ifOne.clearEvt = clr1;
   assign ifTwo.enable = st_q.ctl2[CTL_ON];
   assign ifTwo.invert = st_q.ctl2[CTL_INV];
   assign ifTwo.event_polarity_field = st_q.ctl2[CTL_EVP +: 2];
   assign ifTwo.clearEvt = clr2;

   always_comb begin
      ctl1Rd = st_q.ctl1 & CTL_WMASK;
      ctl1Rd[CTL_EVT] = ifOne.eventFlag;
      ctl1Rd[CTL_RES] = ifOne.result;
      ctl2Rd = st_q.ctl2 & CTL_WMASK;
      ctl2Rd[CTL_EVT] = ifTwo.eventFlag;
      ctl2Rd[CTL_RES] = ifTwo.result;
      stat = REG_RESET;
      stat[ST_EVT2] = ifTwo.eventFlag;
      stat[ST_EVT1] = ifOne.eventFlag;
      stat[ST_RES2] = ifTwo.result;
      stat[ST_RES1] = ifOne.result;
      stat[ST_IDLE] = st_q.idleHalt;
      stat[ST_REF] = st_q.refSel;
   end

   always_comb begin
      ofs = {wb_adr_i[7:4], 4'h0};
      op = dcc_op_t'(wb_adr_i[3:2]);
      hit = (ofs == STAT_OFS) || (ofs == CTL1_OFS) || (ofs == CTL2_OFS);
      // Write lands on the edge where the master samples ack
      wrStb = wb_cyc_i && wb_stb_i && st_q.ack && wb_we_i && hit;
      bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wdat = wb_dat_i & bmask;
      case (ofs)
         STAT_OFS: cur = stat;
         CTL1_OFS: cur = ctl1Rd;
         CTL2_OFS: cur = ctl2Rd;
         default: cur = REG_RESET;
      endcase
      case (op)
         DCC_OP_CLR: nxt = cur & ~wdat;
         DCC_OP_SET: nxt = cur | wdat;
         DCC_OP_INV: nxt = cur ^ wdat;
         default: nxt = (cur & ~bmask) | wdat;
      endcase
   end

   // Event flag is software-clearable; hardware-owned result is not
   assign clr1 = wrStb && ofs == CTL1_OFS && !nxt[CTL_EVT];
   assign clr2 = wrStb && ofs == CTL2_OFS && !nxt[CTL_EVT];

   always_comb begin
      st_d = st_q;
      st_d.idleS1 = sysIdle;
      st_d.idleS2 = st_q.idleS1;
      st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
      if (wb_cyc_i && wb_stb_i && !st_q.ack) begin
         st_d.rdat = cur; // unmapped reads as zero
      end
      if (wrStb) begin
         case (ofs)
            STAT_OFS: begin
               st_d.idleHalt = nxt[ST_IDLE];
               st_d.refSel = nxt[ST_REF];
            end
            CTL1_OFS: st_d.ctl1 = nxt & CTL_WMASK;
            CTL2_OFS: st_d.ctl2 = nxt & CTL_WMASK;
            default: st_d.ctl1 = st_q.ctl1;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = st_q.rdat;
   // Raw, unsynchronised path straight to the pad
   assign resultPinOne = st_q.ctl1[CTL_OE] & st_q.ctl1[CTL_ON]
      & (rawResultOne ^ st_q.ctl1[CTL_INV]);
   assign resultPinTwo = st_q.ctl2[CTL_OE] & st_q.ctl2[CTL_ON]
      & (rawResultTwo ^ st_q.ctl2[CTL_INV]);
   assign enableOne = st_q.ctl1[CTL_ON] & runOk;
   assign enableTwo = st_q.ctl2[CTL_ON] & runOk;
   assign positiveSelOne = st_q.ctl1[CTL_PSEL];
   assign positiveSelTwo = st_q.ctl2[CTL_PSEL];
   assign negativeSelOne = st_q.ctl1[CTL_NSEL +: 2];
   assign negativeSelTwo = st_q.ctl2[CTL_NSEL +: 2];
   assign referenceSourceSelect = st_q.refSel;

   property p_ack_one;
      @(posedge mclk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("ack held more than one cycle");

   property p_stat_evt;
      @(posedge mclk) disable iff (sys_rst)
      stat[ST_EVT2] == ctl2Rd[CTL_EVT] && stat[ST_EVT1] == ctl1Rd[CTL_EVT];
   endproperty
   a_stat_evt: assert property (p_stat_evt)
      else $error("status event mirror wrong");

   property p_stat_res;
      @(posedge mclk) disable iff (sys_rst)
      stat[ST_RES2] == ctl2Rd[CTL_RES] && stat[ST_RES1] == ctl1Rd[CTL_RES];
   endproperty
   a_stat_res: assert property (p_stat_res)
      else $error("status result mirror wrong");

   property p_set_alias;
      @(posedge mclk) disable iff (sys_rst)
      wrStb && ofs == CTL1_OFS && op == DCC_OP_SET && wb_sel_i[1]
         && wb_dat_i[CTL_ON] |=> st_q.ctl1[CTL_ON];
   endproperty
   a_set_alias: assert property (p_set_alias)
      else $error("set alias did not set bit");

   property p_clr_alias;
      @(posedge mclk) disable iff (sys_rst)
      wrStb && ofs == CTL2_OFS && op == DCC_OP_CLR && wb_sel_i[1]
         && wb_dat_i[CTL_ON] |=> !st_q.ctl2[CTL_ON];
   endproperty
   a_clr_alias: assert property (p_clr_alias)
      else $error("clear alias did not clear bit");

   property p_idle_halt;
      @(posedge mclk) disable iff (sys_rst)
      st_q.idleHalt && st_q.idleS2 |-> !enableOne && !enableTwo;
   endproperty
   a_idle_halt: assert property (p_idle_halt)
      else $error("comparator runs in idle with halt set");

   property p_unimpl;
      @(posedge mclk) disable iff (sys_rst)
      wb_ack_o |-> (wb_dat_o & ~(CTL_WMASK | 32'h0003_2303)) == 32'h0;
   endproperty
   a_unimpl: assert property (p_unimpl)
      else $error("unimplemented bits read nonzero");

   property p_pin_off;
      @(posedge mclk) disable iff (sys_rst)
      !st_q.ctl1[CTL_OE] |-> !resultPinOne;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("pin driven while output disabled");

   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_bus_ans;
      wb_ack_o;
   endsequence
   property p_ack_taken;
      @(posedge mclk) disable iff (sys_rst)
      s_bus_req |=> s_bus_ans;
   endproperty
   a_ack_taken: assert property (p_ack_taken)
      else $error("request not answered in next cycle");

   property p_rd_unmapped;
      @(posedge mclk) disable iff (sys_rst)
      s_bus_req ##0 !hit |=> wb_dat_o == REG_RESET;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped offset read nonzero");

   property p_wr_ignored;
      @(posedge mclk) disable iff (sys_rst)
      wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && !hit
         |=> $stable(st_q.ctl1) && $stable(st_q.ctl2)
         && $stable(st_q.idleHalt) && $stable(st_q.refSel);
   endproperty
   a_wr_ignored: assert property (p_wr_ignored)
      else $error("unmapped write changed a register");

   property p_ref_write;
      @(posedge mclk) disable iff (sys_rst)
      wrStb && ofs == STAT_OFS && op == DCC_OP_WR && wb_sel_i[1]
         |=> referenceSourceSelect == $past(wb_dat_i[ST_REF]);
   endproperty
   a_ref_write: assert property (p_ref_write)
      else $error("reference select not written");

   property p_idle_write;
      @(posedge mclk) disable iff (sys_rst)
      wrStb && ofs == STAT_OFS && op == DCC_OP_WR && wb_sel_i[1]
         |=> st_q.idleHalt == $past(wb_dat_i[ST_IDLE]);
   endproperty
   a_idle_write: assert property (p_idle_write)
      else $error("idle halt bit not written");

   property p_inv_alias;
      @(posedge mclk) disable iff (sys_rst)
      wrStb && ofs == CTL1_OFS && op == DCC_OP_INV && wb_sel_i[1]
         && wb_dat_i[CTL_INV]
         |=> st_q.ctl1[CTL_INV] != $past(st_q.ctl1[CTL_INV]);
   endproperty
   a_inv_alias: assert property (p_inv_alias)
      else $error("invert alias did not toggle bit");

   property p_clr_keep;
      @(posedge mclk) disable iff (sys_rst)
      wrStb && ofs == CTL1_OFS && op == DCC_OP_CLR && !wb_dat_i[CTL_ON]
         |=> $stable(st_q.ctl1[CTL_ON]);
   endproperty
   a_clr_keep: assert property (p_clr_keep)
      else $error("clear alias touched a zero bit");

   property p_sel_keep;
      @(posedge mclk) disable iff (sys_rst)
      wrStb && ofs == CTL2_OFS && !wb_sel_i[1]
         |=> $stable(st_q.ctl2[15:8]);
   endproperty
   a_sel_keep: assert property (p_sel_keep)
      else $error("unselected byte lane changed");

   property p_pin_off_two;
      @(posedge mclk) disable iff (sys_rst)
      !st_q.ctl2[CTL_OE] |-> !resultPinTwo;
   endproperty
   a_pin_off_two: assert property (p_pin_off_two)
      else $error("second pin driven while output disabled");

   property p_pin_raw;
      @(posedge mclk) disable iff (sys_rst)
      st_q.ctl1[CTL_OE] && st_q.ctl1[CTL_ON]
         |-> resultPinOne == (rawResultOne ^ st_q.ctl1[CTL_INV]);
   endproperty
   a_pin_raw: assert property (p_pin_raw)
      else $error("pin does not carry raw result");

   property p_run_follow;
      @(posedge mclk) disable iff (sys_rst)
      !st_q.idleHalt |-> enableOne == st_q.ctl1[CTL_ON]
         && enableTwo == st_q.ctl2[CTL_ON];
   endproperty
   a_run_follow: assert property (p_run_follow)
      else $error("enabled comparator stopped without halt");

   property p_evt_clear;
      @(posedge mclk) disable iff (sys_rst)
      wrStb && ofs == CTL1_OFS && op == DCC_OP_WR && wb_sel_i[1]
         && !wb_dat_i[CTL_EVT] && ifOne.eventFlag |=> !ifOne.eventFlag;
   endproperty
   a_evt_clear: assert property (p_evt_clear)
      else $error("event flag not cleared by write");

   sequence s_stat_read;
      s_bus_req ##0 ofs == STAT_OFS;
   endsequence
   property p_rd_evt;
      @(posedge mclk) disable iff (sys_rst)
      s_stat_read |=> wb_dat_o[ST_EVT1] == $past(ifOne.eventFlag)
         && wb_dat_o[ST_EVT2] == $past(ifTwo.eventFlag);
   endproperty
   a_rd_evt: assert property (p_rd_evt)
      else $error("status read lost an event flag");

   property p_rd_res;
      @(posedge mclk) disable iff (sys_rst)
      s_stat_read |=> wb_dat_o[ST_RES1] == $past(ifOne.result)
         && wb_dat_o[ST_RES2] == $past(ifTwo.result);
   endproperty
   a_rd_res: assert property (p_rd_res)
      else $error("status read lost a result bit");

   property p_ctl_rd;
      @(posedge mclk) disable iff (sys_rst)
      s_bus_req ##0 ofs == CTL2_OFS
         |=> (wb_dat_o & CTL_WMASK) == $past(st_q.ctl2);
   endproperty
   a_ctl_rd: assert property (p_ctl_rd)
      else $error("second control read differs from stored value");
endmodule

// ### dcc_pkg.sv
package dcc_pkg;
   // Register byte offsets; alias offsets added to each base
   localparam logic [7:0] STAT_OFS = 8'h00;
   localparam logic [7:0] CTL1_OFS = 8'h10;
   localparam logic [7:0] CTL2_OFS = 8'h20;
   localparam logic [3:0] ALIAS_CLR = 4'h4;
   localparam logic [3:0] ALIAS_SET = 4'h8;
   localparam logic [3:0] ALIAS_INV = 4'hC;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   // Control register fields
   localparam int CTL_ON = 15;
   localparam int CTL_OE = 14;
   localparam int CTL_INV = 13;
   localparam int CTL_EVT = 9;
   localparam int CTL_RES = 8;
   localparam int CTL_EVP = 6;
   localparam int CTL_PSEL = 4;
   localparam int CTL_NSEL = 0;
   localparam logic [31:0] CTL_WMASK = 32'h0000_E0D3;
   // Status register fields
   localparam int ST_EVT2 = 17;
   localparam int ST_EVT1 = 16;
   localparam int ST_IDLE = 13;
   localparam int ST_REF = 8;
   localparam int ST_RES2 = 1;
   localparam int ST_RES1 = 0;
   localparam logic [31:0] ST_WMASK = 32'h0000_2100;
   localparam logic [1:0] EVP_OFF = 2'h0;
   localparam logic [1:0] EVP_ANY = 2'h3;
   typedef enum logic [1:0] {
      DCC_OP_WR = 2'b00,
      DCC_OP_CLR = 2'b01,
      DCC_OP_SET = 2'b10,
      DCC_OP_INV = 2'b11
   } dcc_op_t;
endpackage

// ### dcc_chan_if.sv
`timescale 1ns/1ps
interface dcc_chan_if;
   logic enable;
   logic invert;
   logic [1:0] event_polarity_field;
   logic clearEvt;
   logic result;
   logic eventFlag;
   modport ctl (output enable, invert, event_polarity_field, clearEvt,
      input result, eventFlag);
   modport chan (input enable, invert, event_polarity_field, clearEvt,
      output result, eventFlag);
endinterface

// ### dcc_channel.sv
`timescale 1ns/1ps
module dcc_channel
   import dcc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic rawResult,
   input wire logic runOk,
   dcc_chan_if.chan ch
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic res;
      logic evt;
   } dcc_chan_st_t;
   dcc_chan_st_t st_q, st_d;
   logic newRes, rise, fall, trig;

   always_comb begin
      st_d = st_q;
      // First stage only feeds the second
      st_d.sync1 = rawResult;
      st_d.sync2 = st_q.sync1;
      newRes = st_q.sync2 ^ ch.invert;
      rise = newRes & ~st_q.res;
      fall = ~newRes & st_q.res;
      trig = 1'b0;
      case (ch.event_polarity_field)
         EVP_ANY: trig = rise | fall;
         2'h2: trig = ch.invert ? rise : fall;
         2'h1: trig = ch.invert ? fall : rise;
         default: trig = 1'b0;
      endcase
      if (ch.enable && runOk) begin
         st_d.res = newRes;
         // Clear wins over a trigger in the same cycle once the flag is set
         if (trig && !st_q.evt) begin
            st_d.evt = 1'b1;
         end else if (ch.clearEvt) begin
            st_d.evt = 1'b0;
         end
      end else if (ch.clearEvt) begin
         st_d.evt = 1'b0;
      end
      if (!ch.enable) begin
         st_d.res = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign ch.result = st_q.res;
   assign ch.eventFlag = st_q.evt;

   property p_evt_sticky;
      @(posedge mclk) disable iff (sys_rst)
      st_q.evt && !ch.clearEvt |=> st_q.evt;
   endproperty
   a_evt_sticky: assert property (p_evt_sticky)
      else $error("event flag dropped without clear");

   property p_off_zero;
      @(posedge mclk) disable iff (sys_rst)
      !ch.enable |=> !st_q.res;
   endproperty
   a_off_zero: assert property (p_off_zero)
      else $error("disabled comparator reports result");

   property p_evp_off;
      @(posedge mclk) disable iff (sys_rst)
      ch.event_polarity_field == EVP_OFF && !st_q.evt |=> !st_q.evt;
   endproperty
   a_evp_off: assert property (p_evp_off)
      else $error("event set while events disabled");

   sequence s_stable_in;
      (ch.enable && runOk && !ch.invert && !rawResult) [*3];
   endsequence
   property p_sync_delay;
      @(posedge mclk) disable iff (sys_rst)
      s_stable_in |=> !st_q.res;
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("result does not follow synchronised input");
endmodule

// ### dcc_front_model.sv
`timescale 1ns/1ps
module dcc_front_model (
   input wire logic mclk,
   input wire logic enableOne,
   input wire logic enableTwo,
   input wire logic levelOne,
   input wire logic levelTwo,
   output logic rawResultOne,
   output logic rawResultTwo
);
   // An unpowered front end has no defined result, so it toggles
   initial begin
      rawResultOne = 1'b0;
      rawResultTwo = 1'b0;
   end
   always @(posedge mclk) begin
      rawResultOne <= enableOne ? levelOne : ~rawResultOne;
      rawResultTwo <= enableTwo ? levelTwo : ~rawResultTwo;
   end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dcc_pkg::*;
   logic mclk, sys_rst, wbWe, wbCyc, wbStb, wbAck, sysIdle;
   logic levelOne, levelTwo, rawOne, rawTwo, pinOne, pinTwo;
   logic enOne, enTwo, posOne, posTwo, refSel;
   logic [1:0] negOne, negTwo;
   logic [31:0] wbAdr, wbDatI, wbDatO, rd;
   logic [3:0] wbSel;
   int n_mismatch = 0;
   int tests_run = 0;
   dcc_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .wb_adr_i(wbAdr),
      .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_sel_i(wbSel),
      .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_ack_o(wbAck), .sysIdle(sysIdle), .rawResultOne(rawOne),
      .rawResultTwo(rawTwo), .resultPinOne(pinOne),
      .resultPinTwo(pinTwo), .enableOne(enOne), .enableTwo(enTwo),
      .positiveSelOne(posOne), .positiveSelTwo(posTwo),
      .negativeSelOne(negOne), .negativeSelTwo(negTwo),
      .referenceSourceSelect(refSel));
   dcc_front_model fe_u (.mclk(mclk), .enableOne(enOne),
      .enableTwo(enTwo), .levelOne(levelOne), .levelTwo(levelTwo),
      .rawResultOne(rawOne), .rawResultTwo(rawTwo));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [31:0] got,
      input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge mclk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {24'h0, a};
      wbDatI <= d;
      wbSel <= s;
      do begin
         @(posedge mclk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      rd = wbDatO;
      if (n >= 20) check("ack", 32'h0, 32'h1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      check("register", rd, e);
   endtask
   task automatic setLevel(input int i, input logic v);
      if (i == 0) levelOne <= v;
      else levelTwo <= v;
   endtask
   task automatic t_alias(input int i);
      logic [7:0] b;
      b = (i == 0) ? CTL1_OFS : CTL2_OFS;
      wr(b, 32'hFFFF_7FFF);
      rdchk(b, 32'h0000_60D3);
      check("sel", i ? {posTwo, negTwo} : {posOne, negOne}, 32'h7);
      wr(b + {4'h0, ALIAS_CLR}, 32'h0000_0041);
      rdchk(b, 32'h0000_6092);
      wr(b + {4'h0, ALIAS_SET}, 32'h0000_0204);
      rdchk(b, 32'h0000_6092);
      wr(b + {4'h0, ALIAS_INV}, 32'h0000_2011);
      rdchk(b, 32'h0000_4083);
      check("sel", i ? {posTwo, negTwo} : {posOne, negOne}, 32'h3);
      bus(1'b1, b, 32'h0000_FF00, 4'h1);
      rdchk(b, 32'h0000_4000);
      wr(b, 32'h0);
   endtask
   task automatic t_status;
      wr(STAT_OFS, 32'hFFFF_FFFF);
      rdchk(STAT_OFS, 32'h0000_2100);
      check("ref", {31'h0, refSel}, 32'h1);
      wr(STAT_OFS + {4'h0, ALIAS_INV}, 32'h0000_0100);
      rdchk(STAT_OFS, 32'h0000_2000);
      check("ref", {31'h0, refSel}, 32'h0);
      wr(8'h34, 32'hFFFF_FFFF);
      rdchk(8'h30, 32'h0);
      wr(STAT_OFS, 32'h0);
   endtask
   task automatic t_event(input int i);
      logic [7:0] b;
      logic [31:0] c, e;
      b = (i == 0) ? CTL1_OFS : CTL2_OFS;
      for (int m = 0; m < 4; m++) begin
         c = 32'h0000_8000 | (32'(m) << 6);
         setLevel(i, 1'b0);
         wr(b, 32'h0000_8000);
         repeat (5) @(posedge mclk);
         wr(b, c);
         setLevel(i, 1'b1);
         repeat (6) @(posedge mclk);
         e = (m == 1 || m == 3) ? 32'h200 : 32'h0;
         rdchk(b, c | 32'h100 | e);
         rdchk(STAT_OFS, (e << (7 + i)) | (32'h1 << i));
         setLevel(i, 1'b0);
         repeat (6) @(posedge mclk);
         rdchk(b, c | ((m != 0) ? 32'h200 : 32'h0));
         wr(b, c);
         rdchk(b, c);
      end
      wr(b, 32'h0);
   endtask
   task automatic t_pin(input int i);
      logic [7:0] b;
      b = (i == 0) ? CTL1_OFS : CTL2_OFS;
      setLevel(i, 1'b1);
      wr(b, 32'h0000_C000);
      repeat (6) @(posedge mclk);
      check("pin", {31'h0, i ? pinTwo : pinOne}, 32'h1);
      wr(b + {4'h0, ALIAS_INV}, 32'h0000_6000);
      repeat (4) @(posedge mclk);
      rdchk(b, 32'h0000_A000);
      setLevel(i, 1'b0);
      wr(b + {4'h0, ALIAS_SET}, 32'h0000_4000);
      repeat (4) @(posedge mclk);
      check("pin", {31'h0, i ? pinTwo : pinOne}, 32'h1);
      rdchk(b, 32'h0000_E100);
      wr(b, 32'h0);
      @(posedge mclk);
      check("pin", {31'h0, i ? pinTwo : pinOne}, 32'h0);
   endtask
   task automatic t_idle;
      wr(CTL1_OFS, 32'h0000_8000);
      wr(CTL2_OFS, 32'h0000_8000);
      wr(STAT_OFS, 32'h0000_2000);
      check("enable", {30'h0, enTwo, enOne}, 32'h3);
      sysIdle <= 1'b1;
      repeat (4) @(posedge mclk);
      check("enable", {30'h0, enTwo, enOne}, 32'h0);
      wr(STAT_OFS, 32'h0);
      repeat (3) @(posedge mclk);
      check("enable", {30'h0, enTwo, enOne}, 32'h3);
      sysIdle <= 1'b0;
      wr(CTL1_OFS, 32'h0);
      wr(CTL2_OFS, 32'h0);
      @(posedge mclk);
      check("enable", {30'h0, enTwo, enOne}, 32'h0);
   endtask
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      {wbWe, wbCyc, wbStb, sysIdle, levelOne, levelTwo} = 6'h00;
      wbAdr = 32'h0;
      wbDatI = 32'h0;
      wbSel = 4'h0;
      sys_rst = 1'b1;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rdchk(STAT_OFS, REG_RESET);
      rdchk(CTL1_OFS, REG_RESET);
      rdchk(CTL2_OFS, REG_RESET);
      for (int i = 0; i < 2; i++) begin
         t_alias(i);
         t_event(i);
         t_pin(i);
      end
      t_status;
      t_idle;
      conclude;
   end
   // Whole run is roughly 500 cycles; the 20000-cycle limit leaves ample margin
   initial begin
      #(40 * 20000);
      n_mismatch++;
      conclude;
   end
endmodule
